// ---- rtl/mior_consts.vh ----
/*
 * Constants of the multi-I/O read and page program controller.
 * Assumes it is included by bare name from the design files only.
 */
`ifndef MIOR_CONSTS_VH
`define MIOR_CONSTS_VH

// Flash opcodes
`define MIOR_OPC_DUAL_RD 8'hBB
`define MIOR_OPC_QUAD_RD 8'hEB
`define MIOR_OPC_WORD_RD 8'hE7
`define MIOR_OPC_WRAP 8'h77
`define MIOR_OPC_PROG 8'h02
`define MIOR_OPC_QPROG 8'h32
`define MIOR_OPC_WRITE_ENABLE_CMD 8'h06
`define MIOR_OPC_STATUS 8'h05
`define MIOR_CRM_RST_BYTE 8'hFF

// User command kinds
`define MIOR_K_DUAL_RD 3'h0
`define MIOR_K_QUAD_RD 3'h1
`define MIOR_K_WORD_RD 3'h2
`define MIOR_K_WRAP 3'h3
`define MIOR_K_PROG 3'h4
`define MIOR_K_QPROG 3'h5
`define MIOR_K_CRM_RST 3'h6
`define MIOR_K_WRITE_ENABLE_CMD 3'h7

// Lane widths
`define MIOR_LN1 3'h1
`define MIOR_LN2 3'h2
`define MIOR_LN4 3'h4

// Frame layout
`define MIOR_ADDR_BYTES 9'h003
`define MIOR_QUAD_DUMMY 9'h002
`define MIOR_WORD_DUMMY 9'h001
`define MIOR_CONT_KEY 4'hA
`define MIOR_BUSY_BIT 0

// Timing in i_clk cycles
`define MIOR_SCK_HALF 4'h4
`define MIOR_SCK_LAST (`MIOR_SCK_HALF + `MIOR_SCK_HALF - 4'h1)
`define MIOR_CS_GAP 4'h8

`endif

// ---- rtl/mior_buf2.v ----
/*
 * Two-entry byte buffer with valid and ready on both sides.
 * Assumes a single clock and a synchronous active-low reset.
 */
`timescale 1ns/100ps
module mior_buf2 (
    // System
    input wire i_clk,
    input wire i_rst_n,
    // Fill side
    input wire i_in_valid,
    input wire [7:0] i_in_data,
    output wire o_in_ready,
    // Drain side
    output wire o_out_valid,
    output wire [7:0] o_out_data,
    input wire i_out_ready
);

reg [7:0] d0_r;
reg [7:0] d1_r;
reg v0_r;
reg v1_r;
wire pop;
wire push;

assign pop = v0_r & i_out_ready;
assign push = i_in_valid & ~v1_r;
assign o_in_ready = ~v1_r;
assign o_out_valid = v0_r;
assign o_out_data = d0_r;

always @(posedge i_clk)
begin
    if (!i_rst_n)
    begin
        d0_r <= 8'h00;
        d1_r <= 8'h00;
        v0_r <= 1'b0;
        v1_r <= 1'b0;
    end
    else if (pop)
    begin
        if (v1_r)
        begin
            d0_r <= d1_r;
            d1_r <= i_in_data;
            v1_r <= push;
        end
        else
        begin
            d0_r <= i_in_data;
            v0_r <= push;
        end
    end
    else if (push)
    begin
        if (!v0_r)
        begin
            d0_r <= i_in_data;
            v0_r <= 1'b1;
        end
        else
        begin
            d1_r <= i_in_data;
            v1_r <= 1'b1;
        end
    end
end

endmodule // mior_buf2

// ---- rtl/mior_ctrl.v ----
/*
 * Host-side controller for a serial NOR flash: dual/quad I/O reads with
 * continuous read mode, wrap setup, single and quad page program.
 * Assumes the flash pins are resolved outside from out/oe, and the user
 * knows the flash quad-enable status bit and drives i_quad_enable.
 */
// What this block does
// - BBH: address, mode, data two bits
// - Mode nibble A: next frame skips opcode
// - Host resets continuous mode before other commands
// - EBH: address, mode, four dummy clocks quad
// - Quad reads only with quad enable set
// - E7H: address bit zero cleared, two dummies
// - 77H: opcode, 24 dummy bits, wrap byte
// - Write enable precedes every page program
// - Program: select low, opcode, address, data
// - Select rises only after a whole byte
// - 32H: quad lanes, only with quad enable
// - 06H alone in a frame sets latch
`timescale 1ns/100ps
`include "mior_consts.vh"
module mior_ctrl (
    // System
    input wire i_clk,
    input wire i_rst_n,
    // Command port
    input wire i_cmd_valid,
    input wire [2:0] i_cmd_kind,
    input wire [23:0] i_cmd_addr,
    input wire [7:0] i_cmd_mode,
    input wire [8:0] i_cmd_len,
    input wire i_quad_enable,
    output wire o_cmd_ready,
    output wire o_cmd_done,
    output wire o_cmd_err,
    output wire o_cont_mode,
    // Program data
    input wire i_wr_valid,
    input wire [7:0] i_wr_data,
    output wire o_wr_ready,
    // Read data
    output wire o_rd_valid,
    output wire [7:0] o_rd_data,
    input wire i_rd_ready,
    // Flash pins
    output wire o_cs_n,
    output wire o_sclk,
    output wire [3:0] o_io_out,
    output wire [3:0] o_io_oe,
    input wire [3:0] i_io_in
);

localparam [12:0] S_IDLE = 13'h0001;
localparam [12:0] S_START = 13'h0002;
localparam [12:0] S_CRST = 13'h0004;
localparam [12:0] S_WRITE_ENABLE_CMD = 13'h0008;
localparam [12:0] S_OPC = 13'h0010;
localparam [12:0] S_ADDR = 13'h0020;
localparam [12:0] S_MODE = 13'h0040;
localparam [12:0] S_DUMMY = 13'h0080;
localparam [12:0] S_WDATA = 13'h0100;
localparam [12:0] S_RDATA = 13'h0200;
localparam [12:0] S_POLC = 13'h0400;
localparam [12:0] S_POLR = 13'h0800;
localparam [12:0] S_GAP = 13'h1000;

reg [12:0] st_r;
reg [12:0] next_r;
reg [2:0] kind_r;
reg [23:0] addr_r;
reg [7:0] mode_r;
reg [8:0] len_r;
reg [8:0] bcnt_r;
reg [7:0] sh_r;
reg [2:0] lanes_r;
reg [3:0] clk_left_r;
reg [3:0] div_r;
reg run_r;
reg [3:0] cap_r;
reg [3:0] gap_r;
reg cont_r;
reg [2:0] cont_kind_r;
reg [3:0] io_s1_r;
reg [3:0] io_s2_r;
reg push_r;
reg [7:0] push_data_r;
reg cs_n_r;
reg sclk_r;
reg [3:0] io_out_r;
reg [3:0] io_oe_r;
reg ready_r;
reg done_r;
reg err_r;
reg wr_ready_r;
wire buf_in_ready;
wire rise;
wire fall;
wire byte_end;
wire [7:0] rd_byte;

function [3:0] clocks_of;
    input [2:0] ln;
    begin
        case (ln)
            `MIOR_LN2: clocks_of = 4'h4;
            `MIOR_LN4: clocks_of = 4'h2;
            default: clocks_of = 4'h8;
        endcase
    end
endfunction

function [7:0] shift_in;
    input [7:0] sh;
    input [3:0] cap;
    input [2:0] ln;
    begin
        case (ln)
            `MIOR_LN2: shift_in = {sh[5:0], cap[1:0]};
            `MIOR_LN4: shift_in = {sh[3:0], cap};
            default: shift_in = {sh[6:0], cap[1]};
        endcase
    end
endfunction

function [2:0] lanes_of;
    input [2:0] k;
    begin
        case (k)
            `MIOR_K_DUAL_RD: lanes_of = `MIOR_LN2;
            `MIOR_K_QUAD_RD, `MIOR_K_WORD_RD,
            `MIOR_K_WRAP, `MIOR_K_QPROG: lanes_of = `MIOR_LN4;
            default: lanes_of = `MIOR_LN1;
        endcase
    end
endfunction

function is_read;
    input [2:0] k;
    begin
        is_read = (k == `MIOR_K_DUAL_RD) || (k == `MIOR_K_QUAD_RD) ||
            (k == `MIOR_K_WORD_RD);
    end
endfunction

task load;
    input [7:0] b;
    input [2:0] ln;
    begin
        sh_r <= b;
        lanes_r <= ln;
        clk_left_r <= clocks_of(ln);
        run_r <= 1'b1;
        div_r <= 4'h0;
        cs_n_r <= 1'b0;
    end
endtask

task start_addr;
    begin
        load(addr_r[23:16], lanes_of(kind_r));
        addr_r <= {addr_r[15:0], 8'h00};
        bcnt_r <= `MIOR_ADDR_BYTES;
        st_r <= S_ADDR;
    end
endtask

// Every frame ends on a byte boundary, so select never rises mid-byte
task end_frame;
    input [12:0] nx;
    begin
        cs_n_r <= 1'b1;
        gap_r <= `MIOR_CS_GAP;
        next_r <= nx;
        st_r <= S_GAP;
    end
endtask

assign rise = run_r && (div_r == `MIOR_SCK_HALF - 4'h1);
assign fall = run_r && (div_r == `MIOR_SCK_LAST);
assign byte_end = fall && (clk_left_r == 4'h1);
assign rd_byte = shift_in(sh_r, cap_r, lanes_r);

////////////////////////////////////////////////////////////////////////
always @(posedge i_clk)
begin
    io_s1_r <= i_io_in;
    io_s2_r <= io_s1_r;
    if (!i_rst_n)
    begin
        io_s1_r <= 4'h0;
        io_s2_r <= 4'h0;
    end
end

////////////////////////////////////////////////////////////////////////
always @(posedge i_clk)
begin
    if (!i_rst_n)
    begin
        st_r <= S_IDLE;
        next_r <= S_IDLE;
        kind_r <= 3'h0;
        addr_r <= 24'h00_0000;
        mode_r <= 8'h00;
        len_r <= 9'h000;
        bcnt_r <= 9'h000;
        sh_r <= 8'h00;
        lanes_r <= `MIOR_LN1;
        clk_left_r <= 4'h0;
        div_r <= 4'h0;
        run_r <= 1'b0;
        cap_r <= 4'h0;
        gap_r <= 4'h0;
        cont_r <= 1'b0;
        cont_kind_r <= 3'h0;
        push_r <= 1'b0;
        push_data_r <= 8'h00;
        cs_n_r <= 1'b1;
        sclk_r <= 1'b0;
        ready_r <= 1'b0;
        done_r <= 1'b0;
        err_r <= 1'b0;
        wr_ready_r <= 1'b0;
    end
    else
    begin
        push_r <= 1'b0;
        done_r <= 1'b0;
        err_r <= 1'b0;
        // Bit engine; the state machine below may override on byte end
        if (run_r)
        begin
            div_r <= fall ? 4'h0 : div_r + 4'h1;
        end
        if (rise)
        begin
            sclk_r <= 1'b1;
            cap_r <= io_s2_r;
        end
        if (fall)
        begin
            sclk_r <= 1'b0;
            sh_r <= rd_byte;
            clk_left_r <= clk_left_r - 4'h1;
        end
        if (byte_end)
        begin
            run_r <= 1'b0;
        end
        case (st_r)
            S_IDLE:
            begin
                ready_r <= 1'b1;
                if (ready_r && i_cmd_valid)
                begin
                    ready_r <= 1'b0;
                    kind_r <= i_cmd_kind;
                    addr_r <= i_cmd_addr;
                    if (i_cmd_kind == `MIOR_K_WORD_RD)
                    begin
                        addr_r <= {i_cmd_addr[23:1], 1'b0};
                    end
                    if (i_cmd_kind == `MIOR_K_WRAP)
                    begin
                        addr_r <= 24'h00_0000;
                    end
                    mode_r <= i_cmd_mode;
                    len_r <= i_cmd_len;
                    st_r <= S_START;
                end
            end
            S_START:
            begin
                if (lanes_of(kind_r) == `MIOR_LN4 && kind_r != `MIOR_K_WRAP
                    && !i_quad_enable)
                begin
                    err_r <= 1'b1;
                    st_r <= S_IDLE;
                end
                else if (cont_r && is_read(kind_r) &&
                    kind_r == cont_kind_r)
                begin
                    start_addr;
                end
                else if (cont_r || kind_r == `MIOR_K_CRM_RST)
                begin
                    load(`MIOR_CRM_RST_BYTE, `MIOR_LN1);
                    st_r <= S_CRST;
                end
                else if (kind_r == `MIOR_K_PROG || kind_r == `MIOR_K_QPROG
                    || kind_r == `MIOR_K_WRITE_ENABLE_CMD)
                begin
                    load(`MIOR_OPC_WRITE_ENABLE_CMD, `MIOR_LN1);
                    st_r <= S_WRITE_ENABLE_CMD;
                end
                else
                begin
                    next_r <= S_OPC;
                    st_r <= S_GAP;
                    gap_r <= 4'h0;
                end
            end
            S_CRST:
            begin
                if (byte_end)
                begin
                    cont_r <= 1'b0;
                    end_frame(kind_r == `MIOR_K_CRM_RST ? S_IDLE : S_START);
                end
            end
            S_WRITE_ENABLE_CMD:
            begin
                if (byte_end)
                begin
                    end_frame(kind_r == `MIOR_K_WRITE_ENABLE_CMD ? S_IDLE : S_OPC);
                end
            end
            S_OPC:
            begin
                if (byte_end)
                begin
                    start_addr;
                end
            end
            S_ADDR:
            begin
                if (byte_end)
                begin
                    bcnt_r <= bcnt_r - 9'h001;
                    if (bcnt_r > 9'h001)
                    begin
                        load(addr_r[23:16], lanes_r);
                        addr_r <= {addr_r[15:0], 8'h00};
                    end
                    else if (kind_r == `MIOR_K_PROG ||
                        kind_r == `MIOR_K_QPROG)
                    begin
                        bcnt_r <= len_r;
                        wr_ready_r <= 1'b1;
                        st_r <= S_WDATA;
                    end
                    else
                    begin
                        load(mode_r, lanes_r);
                        st_r <= S_MODE;
                    end
                end
            end
            S_MODE:
            begin
                if (byte_end)
                begin
                    bcnt_r <= len_r;
                    if (kind_r == `MIOR_K_WRAP)
                    begin
                        end_frame(S_IDLE);
                    end
                    else
                    begin
                        cont_r <= (mode_r[7:4] == `MIOR_CONT_KEY);
                        cont_kind_r <= kind_r;
                        st_r <= S_RDATA;
                        if (kind_r != `MIOR_K_DUAL_RD)
                        begin
                            bcnt_r <= (kind_r == `MIOR_K_WORD_RD) ?
                                `MIOR_WORD_DUMMY : `MIOR_QUAD_DUMMY;
                            load(8'h00, `MIOR_LN4);
                            st_r <= S_DUMMY;
                        end
                    end
                end
            end
            S_DUMMY:
            begin
                if (byte_end)
                begin
                    bcnt_r <= bcnt_r - 9'h001;
                    if (bcnt_r > 9'h001)
                    begin
                        load(8'h00, `MIOR_LN4);
                    end
                    else
                    begin
                        bcnt_r <= len_r;
                        st_r <= S_RDATA;
                    end
                end
            end
            S_WDATA:
            begin
                if (wr_ready_r && i_wr_valid && !run_r)
                begin
                    wr_ready_r <= 1'b0;
                    load(i_wr_data, lanes_of(kind_r));
                end
                if (byte_end)
                begin
                    bcnt_r <= bcnt_r - 9'h001;
                    if (bcnt_r > 9'h001)
                    begin
                        wr_ready_r <= 1'b1;
                    end
                    else
                    begin
                        end_frame(S_POLC);
                    end
                end
            end
            S_RDATA:
            begin
                // Clock stays low while the buffer is full: no byte lost
                if (!run_r && buf_in_ready && !push_r)
                begin
                    load(8'h00, lanes_r);
                end
                if (byte_end)
                begin
                    push_r <= 1'b1;
                    push_data_r <= rd_byte;
                    bcnt_r <= bcnt_r - 9'h001;
                    if (bcnt_r <= 9'h001)
                    begin
                        end_frame(S_IDLE);
                    end
                end
            end
            S_POLC:
            begin
                if (byte_end)
                begin
                    load(8'h00, `MIOR_LN1);
                    st_r <= S_POLR;
                end
            end
            S_POLR:
            begin
                if (byte_end)
                begin
                    if (rd_byte[`MIOR_BUSY_BIT])
                    begin
                        load(8'h00, `MIOR_LN1);
                    end
                    else
                    begin
                        end_frame(S_IDLE);
                    end
                end
            end
            S_GAP:
            begin
                gap_r <= gap_r - 4'h1;
                if (gap_r == 4'h0)
                begin
                    st_r <= next_r;
                    done_r <= (next_r == S_IDLE);
                    if (next_r == S_OPC)
                    begin
                        case (kind_r)
                            `MIOR_K_DUAL_RD: load(`MIOR_OPC_DUAL_RD, `MIOR_LN1);
                            `MIOR_K_QUAD_RD: load(`MIOR_OPC_QUAD_RD, `MIOR_LN1);
                            `MIOR_K_WORD_RD: load(`MIOR_OPC_WORD_RD, `MIOR_LN1);
                            `MIOR_K_WRAP: load(`MIOR_OPC_WRAP, `MIOR_LN1);
                            `MIOR_K_QPROG: load(`MIOR_OPC_QPROG, `MIOR_LN1);
                            default: load(`MIOR_OPC_PROG, `MIOR_LN1);
                        endcase
                    end
                    if (next_r == S_POLC)
                    begin
                        load(`MIOR_OPC_STATUS, `MIOR_LN1);
                    end
                end
            end
            default:
            begin
                st_r <= S_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// Pin drivers, one cycle behind the shifter, well inside the low phase
always @(posedge i_clk)
begin
    if (!i_rst_n || cs_n_r)
    begin
        io_out_r <= 4'h0;
        io_oe_r <= 4'h0;
    end
    else if (st_r == S_CRST)
    begin
        io_out_r <= 4'hF;
        io_oe_r <= 4'hF;
    end
    else if (st_r == S_WRITE_ENABLE_CMD || st_r == S_OPC || st_r == S_ADDR ||
        st_r == S_MODE || st_r == S_WDATA || st_r == S_POLC)
    begin
        case (lanes_r)
            `MIOR_LN2:
            begin
                io_out_r <= {2'b00, sh_r[7:6]};
                io_oe_r <= 4'h3;
            end
            `MIOR_LN4:
            begin
                io_out_r <= sh_r[7:4];
                io_oe_r <= 4'hF;
            end
            default:
            begin
                io_out_r <= {3'b000, sh_r[7]};
                io_oe_r <= 4'h1;
            end
        endcase
    end
    else
    begin
        io_out_r <= 4'h0;
        io_oe_r <= 4'h0;
    end
end

mior_buf2 u_rdbuf (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(push_r),
    .i_in_data(push_data_r),
    .o_in_ready(buf_in_ready),
    .o_out_valid(o_rd_valid),
    .o_out_data(o_rd_data),
    .i_out_ready(i_rd_ready)
);

assign o_cmd_ready = ready_r;
assign o_cmd_done = done_r;
assign o_cmd_err = err_r;
assign o_cont_mode = cont_r;
assign o_wr_ready = wr_ready_r;
assign o_cs_n = cs_n_r;
assign o_sclk = sclk_r;
assign o_io_out = io_out_r;
assign o_io_oe = io_oe_r;

endmodule // mior_ctrl

// ---- dv/mior_ctrl_asserts.sv ----
/* Checker of the controller's pin and command-port timing.
   Bound to mior_ctrl in the bench; sees its ports only. */
`timescale 1ns/100ps
module mior_ctrl_asserts (
    // System
    input wire i_clk,
    input wire i_rst_n,
    // Command port
    input wire i_cmd_valid,
    input wire [2:0] i_cmd_kind,
    input wire i_quad_enable,
    input wire o_cmd_ready,
    input wire o_cmd_done,
    input wire o_cmd_err,
    input wire o_cont_mode,
    // Read data and pins
    input wire o_rd_valid,
    input wire [7:0] o_rd_data,
    input wire i_rd_ready,
    input wire o_cs_n,
    input wire o_sclk
);
default clocking cb @(posedge i_clk); endclocking
default disable iff (!i_rst_n);
//////////////////////////////////////////////////
sequence take_s;
    o_cmd_ready && i_cmd_valid;
endsequence
sequence refuse_s;
    take_s ##0 (i_cmd_kind inside {3'h1, 3'h2, 3'h5}) && !i_quad_enable;
endsequence
//////////////////////////////////////////////////
AST_TAKE_DROP: assert property (take_s |=> !o_cmd_ready)
    else $error("ready stayed high after a take");
AST_ERR_TWO: assert property (refuse_s |-> ##2 o_cmd_err)
    else $error("refusal pulse missing");
AST_ERR_QUIET: assert property (o_cmd_err |->
    o_cs_n && $past(o_cs_n) && $past(o_cs_n, 2))
    else $error("refused command touched the pins");
AST_SCLK_HIGH: assert property ($rose(o_sclk) |=>
    o_sclk [*3] ##1 !o_sclk)
    else $error("serial clock high phase wrong");
AST_SCLK_SEL: assert property (o_sclk |-> !o_cs_n)
    else $error("serial clock outside a frame");
AST_CS_GAP: assert property ($rose(o_cs_n) |=> o_cs_n [*8])
    else $error("select gap too short");
AST_DONE_DESEL: assert property (o_cmd_done |-> o_cs_n)
    else $error("done while selected");
AST_CONT_FRAME: assert property ($changed(o_cont_mode) |-> $fell(o_sclk))
    else $error("mode flag changed off a byte end");
AST_RD_HOLD: assert property (o_rd_valid && !i_rd_ready |=>
    o_rd_valid && $stable(o_rd_data))
    else $error("read word lost under stall");
endmodule // mior_ctrl_asserts

// ---- dv/mior_flash_model.sv ----
/* Behavioural serial NOR flash seen from its pins: multi-lane reads,
   continuous mode, wrap, write enable, page programs, status polling.
   Assumes clock idles low and host enables mark its driven lanes. */
`timescale 1ns/100ps
module mior_flash_model #(
    parameter [15:0] PROT_PAGE = 16'h0001,
    parameter integer BUSY_NS = 2000
) (
    // Host pins
    input wire i_cs_n,
    input wire i_sclk,
    input wire [3:0] i_io_out,
    input wire [3:0] i_io_oe,
    input wire i_qe,
    // Lines back to the host
    output wire [3:0] o_io_in
);
logic [7:0] mem [0:1023];
logic [7:0] pg [0:255];
logic [255:0] pgv;
logic [31:0] sh;
logic [3:0] dq = 4'h5;
logic [2:0] wrap = 3'b001;
logic [7:0] cont_op = 8'h00;
logic write_latch = 1'b0;
logic busy = 1'b0;
logic go = 1'b0;
logic ab;
logic part;
// Released lanes flip per frame: a stale level never looks valid
assign o_io_in = (i_io_oe & i_io_out) | (~i_io_oe & dq);
initial for (int i = 0; i < 1024; i++) mem[i] = i[7:0] ^ 8'h5A;
//////////////////////////////////////////////////
task automatic get(input integer w, input integer n);
    sh = 0;
    for (int i = 0; i < n && !ab; i += w)
    begin
        @(posedge i_sclk or posedge i_cs_n);
        part = (i != 0);
        if (i_cs_n)
            ab = 1'b1;
        else
            sh = (w == 1) ? {sh, o_io_in[0]} :
                (w == 2) ? {sh, o_io_in[1:0]} : {sh, o_io_in};
    end
endtask
task automatic put(input integer w, input [7:0] b);
    for (int i = 8 - w; i >= 0 && !ab; i -= w)
    begin
        @(negedge i_sclk or posedge i_cs_n) #1;
        if (i_cs_n)
            ab = 1'b1;
        else
            dq = (w == 4) ? b[i+:4] : (w == 2) ? {2'b00, b[i+:2]} :
                {2'b00, b[i], 1'b0};
    end
endtask
//////////////////////////////////////////////////
always @(negedge i_cs_n)
begin : frame
    logic [7:0] op;
    logic [23:0] a;
    integer w;
    integer c;
    ab = 1'b0;
    op = cont_op;
    if (op == 8'h00)
    begin
        get(1, 8);
        op = sh[7:0];
    end
    w = (op == 8'hBB) ? 2 : 4;
    if (op == 8'hBB || ((op == 8'hEB || op == 8'hE7) && i_qe))
    begin
        get(w, 24);
        a = sh[23:0];
        get(w, 8);
        cont_op = (!ab && sh[7:4] == 4'hA) ? op : 8'h00;
        get(w, (op == 8'hEB) ? 16 : (op == 8'hE7) ? 8 : 0);
        while (!ab)
        begin
            put(w, mem[a[9:0]]);
            c = (8 << wrap[2:1]) - 1;
            a = (op == 8'hBB || wrap[0]) ? a + 24'h1 :
                (a & ~c) | ((a + 24'h1) & c);
        end
    end
    else if (op == 8'h77)
    begin
        get(4, 32);
        if (!ab)
            wrap = sh[6:4];
    end
    else if (op == 8'h06)
    begin
        get(1, 1);
        if (ab)
            write_latch = 1'b1;
    end
    else if (op == 8'h05)
        while (!ab) put(1, {6'h00, write_latch, busy});
    else if (op == 8'h02 || (op == 8'h32 && i_qe))
    begin
        w = (op == 8'h02) ? 1 : 4;
        get(w, 24);
        a = sh[23:0];
        pgv = '0;
        while (!ab)
        begin
            get(w, 8);
            if (!ab)
            begin
                pg[a[7:0]] = sh[7:0];
                pgv[a[7:0]] = 1'b1;
                a[7:0] = a[7:0] + 8'h01;
            end
        end
        if (!part && pgv != 0 && write_latch)
        begin
            busy = 1'b1;
            go = ~go;
            if (a[23:8] != PROT_PAGE)
                for (c = 0; c < 256; c++)
                    if (pgv[c]) mem[{a[9:8], c[7:0]}] = pg[c];
        end
    end
end
always @(go)
begin
    #(BUSY_NS);
    write_latch = 1'b0;
    busy = 1'b0;
end
always @(posedge i_cs_n) dq = ~dq;
endmodule // mior_flash_model

// ---- dv/test_mior_ctrl.sv ----
/* Self-checking bench of the flash controller and its pin model.
   Assumes a 4 ns clock; holds the checker's bind at its foot. */
`timescale 1ns/100ps
module test_mior_ctrl;
logic i_clk = 1'b0;
logic i_rst_n = 1'b0;
logic i_cmd_valid = 1'b0;
logic [2:0] i_cmd_kind = 3'h0;
logic [23:0] i_cmd_addr = 24'h00_0000;
logic [7:0] i_cmd_mode = 8'h00;
logic [8:0] i_cmd_len = 9'h000;
logic i_quad_enable = 1'b1;
logic i_wr_valid = 1'b0;
logic [7:0] i_wr_data;
logic i_rd_ready = 1'b0;
wire o_cmd_ready, o_cmd_done, o_cmd_err, o_cont_mode, o_wr_ready;
wire o_rd_valid, o_cs_n, o_sclk;
wire [7:0] o_rd_data;
wire [3:0] o_io_out, o_io_oe, io_in;
integer fails = 0;
integer n_tests = 0;
integer cyc = 0;
logic [8:0] widx = 9'h000;
logic got_err;
logic [7:0] rq [$];
mior_ctrl dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_cmd_valid(i_cmd_valid), .i_cmd_kind(i_cmd_kind),
    .i_cmd_addr(i_cmd_addr), .i_cmd_mode(i_cmd_mode),
    .i_cmd_len(i_cmd_len), .i_quad_enable(i_quad_enable),
    .o_cmd_ready(o_cmd_ready), .o_cmd_done(o_cmd_done),
    .o_cmd_err(o_cmd_err), .o_cont_mode(o_cont_mode),
    .i_wr_valid(i_wr_valid), .i_wr_data(i_wr_data),
    .o_wr_ready(o_wr_ready), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .i_rd_ready(i_rd_ready), .o_cs_n(o_cs_n),
    .o_sclk(o_sclk), .o_io_out(o_io_out), .o_io_oe(o_io_oe),
    .i_io_in(io_in));
mior_flash_model u_flash (.i_cs_n(o_cs_n), .i_sclk(o_sclk),
    .i_io_out(o_io_out), .i_io_oe(o_io_oe), .i_qe(i_quad_enable),
    .o_io_in(io_in));
//////////////////////////////////////////////////
function automatic [7:0] wd(input [8:0] i);
    wd = i[7:0] + {i[8], 6'h00};
endfunction
assign i_wr_data = wd(widx);
initial forever #2 i_clk = ~i_clk;
// Stall patterns keep buffers and data gaps busy
always @(posedge i_clk)
begin
    cyc <= cyc + 1;
    i_rd_ready <= cyc[5];
    i_wr_valid <= (cyc[3:0] != 4'h0) || (i_wr_valid && !o_wr_ready);
    if (o_rd_valid === 1'b1 && i_rd_ready === 1'b1)
        rq.push_back(o_rd_data);
    if (o_wr_ready === 1'b1 && i_wr_valid === 1'b1)
        widx <= widx + 9'h001;
    if (cyc == 60000)
    begin
        fails++;
        report_and_stop();
    end
end
//////////////////////////////////////////////////
task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
        fails++;
        $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
endtask
task automatic cmd(input [2:0] k, input [23:0] a, input [7:0] m,
    input [8:0] n);
    rq.delete();
    widx <= 9'h000;
    i_cmd_kind <= k;
    i_cmd_addr <= a;
    i_cmd_mode <= m;
    i_cmd_len <= n;
    i_cmd_valid <= 1'b1;
    do @(posedge i_clk); while (o_cmd_ready !== 1'b1);
    i_cmd_valid <= 1'b0;
    do @(posedge i_clk); while (o_cmd_done !== 1'b1 && o_cmd_err !== 1'b1);
    got_err = o_cmd_err;
    while (!got_err && k < 3'h3 && rq.size() < n) @(posedge i_clk);
endtask
task automatic rdchk(input [23:0] a, input integer n, input integer l);
    chk("count", rq.size(), n);
    for (int i = 0; i < n; i++)
    begin
        chk("rdata", rq[i], a[7:0] ^ 8'h5A);
        a = (l == 0) ? a + 1 : (a & ~(l - 1)) | ((a + 1) & (l - 1));
    end
endtask
//////////////////////////////////////////////////
task automatic t_dual;
    cmd(3'h0, 24'h00_0120, 8'hA5, 9'h003);
    rdchk(24'h00_0120, 3, 0);
    chk("cont", o_cont_mode, 1);
    cmd(3'h0, 24'h00_01FE, 8'h00, 9'h004);
    rdchk(24'h00_01FE, 4, 0);
    chk("cont", o_cont_mode, 0);
endtask
task automatic t_refuse;
    logic [2:0] qk [3] = '{3'h1, 3'h2, 3'h5};
    i_quad_enable <= 1'b0;
    for (int j = 0; j < 3; j++)
    begin
        cmd(qk[j], 24'h00_0100, 8'h00, 9'h001);
        chk("err", got_err, 1);
    end
    i_quad_enable <= 1'b1;
endtask
task automatic t_wrap;
    for (int j = 0; j < 4; j++)
    begin
        cmd(3'h3, 24'h00_0000, {1'b0, j[1:0], 5'h00}, 9'h001);
        cmd(3'h1, 24'h00_0100 + (8 << j) - 2, 8'h00, 9'h004);
        rdchk(24'h00_0100 + (8 << j) - 2, 4, 8 << j);
    end
    cmd(3'h2, 24'h00_017F, 8'h00, 9'h003);
    rdchk(24'h00_017E, 3, 64);
    cmd(3'h3, 24'h00_0000, 8'h10, 9'h001);
    cmd(3'h1, 24'h00_01FE, 8'hA0, 9'h004);
    rdchk(24'h00_01FE, 4, 0);
    chk("cont", o_cont_mode, 1);
    cmd(3'h6, 24'h00_0000, 8'h00, 9'h001);
    chk("cont", o_cont_mode, 0);
endtask
task automatic t_prog;
    cmd(3'h7, 24'h00_0000, 8'h00, 9'h001);
    chk("latch", u_flash.write_latch, 1);
    cmd(3'h4, 24'h00_0300, 8'h00, 9'h102);
    chk("busy", u_flash.busy, 0);
    chk("latch", u_flash.write_latch, 0);
    for (int c = 0; c < 256; c++)
        chk("page", u_flash.mem[10'h300 + c], c < 2 ? c + 64 : c);
    cmd(3'h5, 24'h00_0210, 8'h00, 9'h002);
    chk("qpage", {u_flash.mem[10'h210], u_flash.mem[10'h211],
        u_flash.mem[10'h212]}, 24'h00_0148);
    cmd(3'h4, 24'h00_01C0, 8'h00, 9'h001);
    chk("prot", u_flash.mem[10'h1C0], 8'h9A);
endtask
task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
initial
begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_dual();
    t_refuse();
    t_wrap();
    t_prog();
    report_and_stop();
end
endmodule // test_mior_ctrl
bind mior_ctrl mior_ctrl_asserts u_chk (.*);
